// [design/cmbr_unit.sv]
// serial bit unit: multi-bit store and fetch sequencer behind an apb slave
`timescale 1ns/1ps
module cmbr_unit
  import cmbr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output cmbr_bus_s        bus_out,
  input  wire logic        serial_in_line,
  input  wire logic        reader_interrupt_n,
  output logic             irq
);

  logic [15:0]               software_base_register;
  logic [15:0]               operand;
  logic [15:0]               result;
  logic [CMBR_IRQ_W-1:0]     irq_stat;
  logic [CMBR_IRQ_W-1:0]     irq_mask;
  cmbr_state_e               state;
  logic [3:0]                idx;
  logic [3:0]                last_idx;
  logic                      fetch_dir;
  logic [CMBR_BIT_ADDR_W-1:0] base_hw;
  logic                      rint_s;
  logic                      rint_d;
  logic                      wr_en;
  logic                      rd_en;
  logic                      addr_ok;
  logic                      start;
  logic                      op_done;
  logic                      reader_evt;
  logic                      busy;

  // bit address: hardware base plus bit index, wraps within the 12-bit field
  function automatic logic [CMBR_BIT_ADDR_W-1:0] bit_addr_of(
    input logic [CMBR_BIT_ADDR_W-1:0] b,
    input logic [3:0]                 i
  );
    bit_addr_of = b + {8'h00, i};
  endfunction

  // mask of the bits gathered for a given last index
  function automatic logic [15:0] low_mask(input logic [3:0] l);
    low_mask = 16'hffff >> (4'hf - l);
  endfunction

  // serial input is decoded from our own registered address, so it is sampled raw;
  // a synchroniser would land each bit cycles late and shift the fetch

  cmbr_sync #(.RST_VAL(1'b1)) u_rint_sync
  (
    .clk    (clk),
    .arst_n (arst_n),
    .din    (reader_interrupt_n),
    .dout   (rint_s)
  );

  // apb: zero wait states, error on unmapped offsets
  assign busy    = (state != CMBR_IDLE);
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && !pwrite;
  assign addr_ok = (paddr[31:8] == 24'h000000) && (paddr[1:0] == 2'h0) &&
                   (paddr[7:0] <= CMBR_OFF_IRQ_MSK);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  // a start while busy is dropped so a second start never corrupts a running sequence
  assign start   = wr_en && addr_ok && (paddr[7:0] == CMBR_OFF_CTRL) && !busy;
  assign op_done = (state == CMBR_STROBE) && (idx == last_idx);
  assign irq     = |(irq_stat & irq_mask);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      prdata <= 32'h00000000;
    else if (rd_en && !penable)
    begin
      unique case (paddr[7:0])
        CMBR_OFF_BASE:    prdata <= {16'h0000, software_base_register};
        CMBR_OFF_OPERAND: prdata <= {16'h0000, operand};
        CMBR_OFF_CTRL:    prdata <= {23'h000000, busy, 3'h0, fetch_dir, last_idx + 4'h1};
        CMBR_OFF_RESULT:  prdata <= {16'h0000, result};
        CMBR_OFF_IRQ_ST:  prdata <= {30'h00000000, irq_stat};
        CMBR_OFF_IRQ_MSK: prdata <= {30'h00000000, irq_mask};
        default:          prdata <= 32'h00000000;
      endcase
    end
  end

  // only software writes the base; the sequencer copies it at start
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      software_base_register <= CMBR_RST_BASE;
      operand                <= CMBR_RST_OPERAND;
      irq_mask               <= CMBR_RST_IRQ;
    end
    else if (wr_en && addr_ok)
    begin
      if (paddr[7:0] == CMBR_OFF_BASE)
        software_base_register <= pwdata[15:0];
      if (paddr[7:0] == CMBR_OFF_OPERAND)
        operand <= pwdata[15:0];
      if (paddr[7:0] == CMBR_OFF_IRQ_MSK)
        irq_mask <= pwdata[CMBR_IRQ_W-1:0];
    end
  end

  // sticky events; a new event wins over a write-one clear in the same cycle
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irq_stat <= CMBR_RST_IRQ;
      rint_d   <= 1'b1;
    end
    else
    begin
      rint_d   <= rint_s;
      irq_stat <= (irq_stat &
                   ~((wr_en && addr_ok && paddr[7:0] == CMBR_OFF_IRQ_ST) ?
                     pwdata[CMBR_IRQ_W-1:0] : 2'h0)) |
                  {reader_evt, op_done};
    end
  end
  // reader asks for service when its active-low interrupt falls
  assign reader_evt = rint_d && !rint_s;

  // sequencer: each bit takes a setup clock then a strobe clock
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state     <= CMBR_IDLE;
      idx       <= 4'h0;
      last_idx  <= 4'h0;
      fetch_dir <= 1'b0;
      base_hw   <= 12'h000;
    end
    else
    begin
      unique case (state)
        CMBR_IDLE:
        begin
          if (start)
          begin
            // count field zero means sixteen bits
            last_idx  <= pwdata[CMBR_CTRL_CNT_LSB +: CMBR_CTRL_CNT_W] - 4'h1;
            fetch_dir <= pwdata[CMBR_CTRL_DIR_BIT];
            base_hw   <= software_base_register[12:1];
            idx       <= 4'h0;
            state     <= CMBR_SETUP;
          end
        end
        CMBR_SETUP:
          state <= CMBR_STROBE;
        CMBR_STROBE:
        begin
          if (idx == last_idx)
            state <= CMBR_IDLE;
          else
          begin
            idx   <= idx + 4'h1;
            state <= CMBR_SETUP;
          end
        end
      endcase
    end
  end

  // pins: address and data set up first, strobe in the second clock
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      bus_out <= '0;
    else
    begin
      bus_out.ctl        <= CMBR_DATA_CTL;
      bus_out.bit_strobe <= (state == CMBR_SETUP) && !fetch_dir;
      if (state == CMBR_IDLE && start)
      begin
        // first cycle carries the operand lsb at the base address
        bus_out.bit_addr        <= bit_addr_of(software_base_register[12:1], 4'h0);
        bus_out.serial_out_line <= !pwdata[CMBR_CTRL_DIR_BIT] && operand[0];
      end
      else if (state == CMBR_STROBE && idx != last_idx)
      begin
        // next address, next higher operand bit
        bus_out.bit_addr        <= bit_addr_of(base_hw, idx + 4'h1);
        bus_out.serial_out_line <= !fetch_dir && operand[idx + 4'h1];
      end
    end
  end

  // fetch: sample input in the second clock, upper bits cleared at start
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      result <= CMBR_RST_RESULT;
    else if (start && pwdata[CMBR_CTRL_DIR_BIT])
      result <= 16'h0000;
    else if (state == CMBR_STROBE && fetch_dir)
      result[idx] <= serial_in_line;
  end

  // checks
  int unsigned strobe_cnt;
  logic [3:0]  op_last;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      strobe_cnt <= 0;
    else if (start)
      strobe_cnt <= 0;
    else if (bus_out.bit_strobe)
      strobe_cnt <= strobe_cnt + 1;
  end
  assign op_last = last_idx;

  sequence bit_cycle_s;
    (state == CMBR_SETUP) ##1 (state == CMBR_STROBE);
  endsequence

  sequence store_start_s;
    start && !pwdata[CMBR_CTRL_DIR_BIT];
  endsequence

  strobe_width_a: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(bus_out.bit_strobe) |=> !bus_out.bit_strobe)
    else $error("bit strobe wider than one clock");

  strobe_stable_a: assert property (@(posedge clk) disable iff (!arst_n)
    bus_out.bit_strobe |-> $stable(bus_out.bit_addr) && $stable(bus_out.serial_out_line))
    else $error("address or data moved under strobe");

  two_clock_a: assert property (@(posedge clk) disable iff (!arst_n)
    (state == CMBR_SETUP) |-> bit_cycle_s)
    else $error("bit cycle not two clocks");

  first_bit_a: assert property (@(posedge clk) disable iff (!arst_n)
    store_start_s |=> (bus_out.serial_out_line == operand[0]) &&
                      (bus_out.bit_addr == software_base_register[12:1]) ##1
                      bus_out.bit_strobe)
    else $error("first store bit wrong");

  addr_step_a: assert property (@(posedge clk) disable iff (!arst_n)
    (state == CMBR_STROBE && idx != last_idx) |=>
      bus_out.bit_addr == $past(bus_out.bit_addr) + 12'h001)
    else $error("bit address did not step by one");

  strobe_count_a: assert property (@(posedge clk) disable iff (!arst_n)
    (op_done && !fetch_dir) |=> strobe_cnt == ({28'h0000000, op_last} + 1))
    else $error("store strobe count differs from bit count");

  no_fetch_strobe_a: assert property (@(posedge clk) disable iff (!arst_n)
    (busy && fetch_dir) |=> !bus_out.bit_strobe)
    else $error("strobe issued during fetch");

  base_kept_a: assert property (@(posedge clk) disable iff (!arst_n)
    !(wr_en && paddr[7:0] == CMBR_OFF_BASE) |=> $stable(software_base_register))
    else $error("base register changed without software write");

  fetch_zero_a: assert property (@(posedge clk) disable iff (!arst_n)
    (op_done && fetch_dir) |=> (result & ~low_mask(op_last)) == 16'h0000)
    else $error("upper fetch bits not zero");

  fetch_sample_a: assert property (@(posedge clk) disable iff (!arst_n)
    (state == CMBR_STROBE && fetch_dir) |=> result[$past(idx)] == $past(serial_in_line))
    else $error("input bit not taken in second clock");

  data_ctl_a: assert property (@(posedge clk) disable iff (!arst_n)
    bus_out.bit_strobe |-> bus_out.ctl == CMBR_DATA_CTL)
    else $error("strobe with nonzero control lines");

  done_flag_a: assert property (@(posedge clk) disable iff (!arst_n)
    op_done |=> irq_stat[CMBR_IRQ_DONE])
    else $error("done flag not set at end of sequence");

endmodule

// [design/cmbr_pkg.sv]
// package: register map, field layout, states and pin carrier for the serial bit unit
package cmbr_pkg;

  // apb byte offsets
  localparam logic [7:0] CMBR_OFF_BASE    = 8'h00;
  localparam logic [7:0] CMBR_OFF_OPERAND = 8'h04;
  localparam logic [7:0] CMBR_OFF_CTRL    = 8'h08;
  localparam logic [7:0] CMBR_OFF_RESULT  = 8'h0c;
  localparam logic [7:0] CMBR_OFF_IRQ_ST  = 8'h10;
  localparam logic [7:0] CMBR_OFF_IRQ_MSK = 8'h14;

  // control register fields
  localparam int CMBR_CTRL_CNT_LSB = 0;
  localparam int CMBR_CTRL_CNT_W   = 4;
  localparam int CMBR_CTRL_DIR_BIT = 4;
  localparam int CMBR_CTRL_BSY_BIT = 8;

  // interrupt status bits
  localparam int CMBR_IRQ_DONE   = 0;
  localparam int CMBR_IRQ_READER = 1;
  localparam int CMBR_IRQ_W      = 2;

  // reset values
  localparam logic [15:0] CMBR_RST_BASE    = 16'h0000;
  localparam logic [15:0] CMBR_RST_OPERAND = 16'h0000;
  localparam logic [15:0] CMBR_RST_RESULT  = 16'h0000;
  localparam logic [1:0]  CMBR_RST_IRQ     = 2'h0;

  // bit cycle length in processor clocks
  localparam int CMBR_BIT_CYCLE_CLKS = 2;

  // bit address width on the bus, and control field forced to zero for data
  localparam int          CMBR_BIT_ADDR_W = 12;
  localparam logic [2:0]  CMBR_DATA_CTL   = 3'h0;

  typedef enum logic [2:0] {
    CMBR_IDLE   = 3'b001,
    CMBR_SETUP  = 3'b010,
    CMBR_STROBE = 3'b100
  } cmbr_state_e;

  typedef struct packed {
    logic [2:0]  ctl;
    logic [11:0] bit_addr;
    logic        serial_out_line;
    logic        bit_strobe;
  } cmbr_bus_s;

endpackage

// [design/cmbr_sync.sv]
// three-flop input synchroniser with agreement filter
`timescale 1ns/1ps
module cmbr_sync
  import cmbr_pkg::*;
#(
  parameter logic RST_VAL = 1'b0
)
(
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic din,
  output logic      dout
);

  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1 <= RST_VAL;
      s2 <= RST_VAL;
      s3 <= RST_VAL;
    end
    else
    begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // s1 feeds only s2; a change counts once the later two agree
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      dout <= RST_VAL;
    else if (s2 == s3)
      dout <= s3;
  end

endmodule

// [verif/cmbr_reader_model.sv]
// paper tape reader with its select, input mux, interrupt flop and run latch
`timescale 1ns/1ps
module cmbr_reader_model
  import cmbr_pkg::*;
#(
  parameter logic [8:0] SEL_ADDR = 9'h040
)
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  cmbr_bus_s       bus,
  input  wire logic       sprocket,
  input  wire logic [7:0] data_n,
  output logic            serial_in_line,
  output logic            reader_interrupt_n,
  output logic            reader_run_enable
);
  logic reader_select_n;
  logic last;
  logic spr_q;

  assign reader_select_n = !(bus.bit_addr[11:3] == SEL_ADDR);
  // released line flips every clock so a stale level never reads as data
  assign serial_in_line = !reader_select_n ? !data_n[bus.bit_addr[2:0]] : !last;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      last <= 1'b0;
      spr_q <= 1'b0;
      reader_interrupt_n <= 1'b1;
      reader_run_enable <= 1'b0;
    end
    else
    begin
      last <= serial_in_line;
      spr_q <= sprocket;
      // reader runs while this latch is one
      if (bus.bit_strobe && !reader_select_n && bus.ctl == 3'h0)
      begin
        reader_interrupt_n <= 1'b1;
        reader_run_enable <= bus.serial_out_line;
      end
      else if (sprocket && !spr_q)
        reader_interrupt_n <= 1'b0;
    end
  end
endmodule

// [verif/cmbr_unit_test.sv]
// self-checking bench for the serial bit unit with a reader on its bit bus
`timescale 1ns/1ps
module cmbr_unit_test
  import cmbr_pkg::*;
;
  logic        clk, arst_n, psel, penable, pwrite, pready, pslverr, irq, err;
  logic        sin, rint_n, run_en, sprocket;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [7:0]  data_n;
  logic [11:0] prev_addr;
  cmbr_bus_s   bus_out;
  int          fails, cmp_count, cyc;
  logic [11:0] s_addr[$];
  logic        s_data[$];
  int          s_cyc[$];
  logic [15:0] r_base [4] = '{16'h0800, 16'h1ffe, 16'h0033, 16'h0400};
  logic [15:0] r_op   [4] = '{16'h02a5, 16'h8001, 16'h0001, 16'h0001};
  logic [3:0]  r_cnt  [4] = '{4'ha, 4'h0, 4'h1, 4'h1};
  int          r_n    [4] = '{10, 16, 1, 1};
  logic [7:0]  offs   [5] = '{CMBR_OFF_BASE, CMBR_OFF_OPERAND, CMBR_OFF_RESULT,
                              CMBR_OFF_IRQ_ST, CMBR_OFF_IRQ_MSK};

  cmbr_unit dut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus_out(bus_out), .serial_in_line(sin),
    .reader_interrupt_n(rint_n), .irq(irq));
  cmbr_reader_model reader (.clk(clk), .arst_n(arst_n), .bus(bus_out),
    .sprocket(sprocket), .data_n(data_n), .serial_in_line(sin),
    .reader_interrupt_n(rint_n), .reader_run_enable(run_en));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (fails == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // apb transfer: request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic run(input logic dir, input logic [3:0] cnt, input logic [15:0] base,
                     input logic [15:0] opnd);
    s_addr.delete();
    s_data.delete();
    s_cyc.delete();
    apb(1'b1, CMBR_OFF_BASE, {16'h0, base});
    apb(1'b1, CMBR_OFF_OPERAND, {16'h0, opnd});
    apb(1'b1, CMBR_OFF_CTRL, {27'h0, dir, cnt});
    rd = 32'h100;
    for (int t = 0; t < 40 && rd[8] === 1'b1; t++)
      apb(1'b0, CMBR_OFF_CTRL, 32'h0);
    apb(1'b0, CMBR_OFF_IRQ_ST, 32'h0);
    check(32'(rd[0]), 32'h1);
    apb(1'b1, CMBR_OFF_IRQ_ST, 32'h1);
  endtask

  // strobe monitor: records address, data and cycle of every output bit
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    prev_addr <= bus_out.bit_addr;
    if (bus_out.bit_strobe === 1'b1)
    begin
      s_addr.push_back(bus_out.bit_addr);
      s_data.push_back(bus_out.serial_out_line);
      s_cyc.push_back(cyc);
      check(32'(bus_out.bit_addr), 32'(prev_addr));
      check(32'(bus_out.ctl), 32'(CMBR_DATA_CTL));
    end
  end

  // watchdog sized far beyond the few hundred cycles the run needs
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    results();
  end

  initial
  begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    sprocket = 1'b0;
    data_n = 8'hff;
    fails = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    check(32'(rint_n), 32'h1);
    check(32'(run_en), 32'h0);
    check(32'(irq), 32'h0);
    foreach (offs[i])
    begin
      apb(1'b0, offs[i], 32'h0);
      check(rd, 32'h0);
    end
    for (int i = 0; i < 4; i++)
    begin
      run(1'b0, r_cnt[i], r_base[i], r_op[i]);
      check(32'(s_addr.size()), 32'(r_n[i]));
      for (int k = 0; k < s_addr.size() && k < r_n[i]; k++)
      begin
        check(32'(s_addr[k]), 32'(12'(r_base[i][12:1] + k)));
        check(32'(s_data[k]), 32'(r_op[i][k]));
        if (k > 0)
          check(32'(s_cyc[k] - s_cyc[k-1]), 32'(CMBR_BIT_CYCLE_CLKS));
      end
      apb(1'b0, CMBR_OFF_BASE, 32'h0);
      check(rd, {16'h0, r_base[i]});
    end
    check(32'(run_en), 32'h1);
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    check(32'(run_en), 32'h0);
    arst_n <= 1'b1;
    // restarts the reader after reset and parks the bus on its addresses
    run(1'b0, 4'h1, 16'h0400, 16'h0001);
    for (int i = 0; i < 3; i++)
    begin
      data_n <= (i == 0) ? 8'h5a : (i == 1) ? 8'h02 : 8'hff;
      run(1'b1, (i == 1) ? 4'h3 : 4'h8, 16'h0400, 16'hffff);
      check(32'(s_addr.size()), 32'h0);
      apb(1'b0, CMBR_OFF_RESULT, 32'h0);
      check(rd, (i == 0) ? 32'ha5 : (i == 1) ? 32'h5 : 32'h0);
    end
    sprocket <= 1'b1;
    repeat (8) @(posedge clk);
    check(32'(rint_n), 32'h0);
    check(32'(irq), 32'h0);
    apb(1'b0, CMBR_OFF_IRQ_ST, 32'h0);
    check(32'(rd[CMBR_IRQ_READER]), 32'h1);
    apb(1'b1, CMBR_OFF_IRQ_MSK, 32'h2);
    @(posedge clk);
    check(32'(irq), 32'h1);
    run(1'b0, 4'h1, 16'h0400, 16'h0000);
    check(32'(rint_n), 32'h1);
    check(32'(run_en), 32'h0);
    apb(1'b1, CMBR_OFF_IRQ_ST, 32'h2);
    @(posedge clk);
    check(32'(irq), 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    apb(1'b1, CMBR_OFF_RESULT, 32'hffff);
    apb(1'b0, CMBR_OFF_RESULT, 32'h0);
    check(rd, 32'h0);
    results();
  end
endmodule
